/* rtl/odtc_consts.svh */
// Constants for the termination control block: timing, counts and defaults
`ifndef ODTC_CONSTS_SVH
`define ODTC_CONSTS_SVH

// Clock period in picoseconds (25 MHz)
`define ODTC_CLK_PERIOD_PS 40000
// Asynchronous turn-on and turn-off windows in picoseconds
`define ODTC_AONPD_MIN_PS  2000
`define ODTC_AONPD_MAX_PS  8500
`define ODTC_AOFPD_MIN_PS  2000
`define ODTC_AOFPD_MAX_PS  8500
// Least time rounds up, longest rounds down, never below one cycle
`define ODTC_CYC_MIN(ps) ((((ps) + `ODTC_CLK_PERIOD_PS - 1) / `ODTC_CLK_PERIOD_PS) < 1 ? 1 : \
   (((ps) + `ODTC_CLK_PERIOD_PS - 1) / `ODTC_CLK_PERIOD_PS))
`define ODTC_CYC_MAX(ps) (((ps) / `ODTC_CLK_PERIOD_PS) < 1 ? 1 : ((ps) / `ODTC_CLK_PERIOD_PS))
// Minimum termination high times in cycles
`define ODTC_HIGH_BC4      4
`define ODTC_HIGH_BL8      6
// Default cycle counts of the surrounding timings
`define ODTC_CPDED_DEF     1
`define ODTC_XPDLL_DEF     10
`define ODTC_RFC_DEF       64
// Depth of the synchronous latency line
`define ODTC_PIPE_DEPTH    32

`endif

/* rtl/odtc_pkg.sv */
// Types shared by the termination control block
package odtc_pkg;

   // Decoded commands from the command decoder, same clock
   typedef struct packed {
      logic write;    // Write registered
      logic bc4;      // Write is burst chop four
      logic read;     // Read registered
      logic refresh;  // Refresh registered
   } odtc_cmd_t;

   // Termination state seen by the output stage
   typedef struct packed {
      logic rtt_on;      // Termination resistance enabled
      logic async_mode;  // Responding asynchronously in power-down
      logic transition;  // Inside an entry or exit transition period
      logic in_pd;       // Clock enable registered low
   } odtc_status_t;

   // Sticky controller misuse flags
   typedef struct packed {
      logic cmd_in_pd;   // Read or write seen during power-down
      logic short_high;  // Termination input dropped too early
   } odtc_viol_t;

endpackage

/* rtl/odtc_top.sv */
// Termination control with asynchronous power-down mode and transitions
// Operation
// - Frozen DLL select zero enables asynchronous timing
// - Asynchronous path ignores additive latency
// - Asynchronous turn-on between two and 8.5 ns; here one 40 ns cycle after the synchronised sample
// - Asynchronous turn-off between two and 8.5 ns; here one 40 ns cycle after the synchronised sample
// - No read or write during power-down
// - Entry period spans lead to command delay
// - Refresh in progress extends entry period
// - Turn-on inside transition bounded by both
// - Turn-off inside transition bounded by both
// - Exit period spans lead to exit delay
// - Overlap entry then exit: either response
// - Overlap exit then entry: either response
`timescale 1ns/10ps
`include "odtc_consts.svh"

module odtc_top
   import odtc_pkg::*;
#(
   parameter logic [7:0] CPDED_CYC = 8'(`ODTC_CPDED_DEF),  // Minimum command delay after entry
   parameter logic [7:0] XPDLL_CYC = 8'(`ODTC_XPDLL_DEF),  // Exit delay with DLL frozen
   parameter logic [7:0] RFC_CYC   = 8'(`ODTC_RFC_DEF)     // Refresh cycle time
) (
   input  wire  logic         clk_i,                // 25 MHz clock
   input  wire  logic         nrst_i,               // Synchronous reset, active low
   input  wire  logic         odt_pin_i,            // Termination input pin
   input  wire  logic         cke_pin_i,            // Clock enable pin
   input  wire  logic         dll_freeze_select_i,  // Mode register zero field
   input  wire  logic [4:0]   write_latency_i,      // Write latency in cycles
   input  wire  odtc_cmd_t    cmd_i,                // Decoded commands
   input  wire  logic         viol_clr_i,           // Clears misuse flags
   output odtc_status_t       status_o,             // Termination state
   output odtc_viol_t         viol_o                // Sticky misuse flags
);

   localparam int PD = `ODTC_PIPE_DEPTH;
   localparam int ON_MIN  = `ODTC_CYC_MIN(`ODTC_AONPD_MIN_PS);
   localparam int ON_MAX  = `ODTC_CYC_MAX(`ODTC_AONPD_MAX_PS);
   localparam int OFF_MIN = `ODTC_CYC_MIN(`ODTC_AOFPD_MIN_PS);
   localparam int OFF_MAX = `ODTC_CYC_MAX(`ODTC_AOFPD_MAX_PS);
   localparam logic [2:0] H4 = 3'(`ODTC_HIGH_BC4 - 1);
   localparam logic [2:0] H8 = 3'(`ODTC_HIGH_BL8 - 1);

   // Counter step toward zero
   function automatic logic [7:0] dec8(input logic [7:0] v);
      dec8 = (v != 8'h00) ? v - 8'h01 : 8'h00;
   endfunction

   // Larger of two counts
   function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
      max8 = (a > b) ? a : b;
   endfunction

   // Tap of the latency line giving a delay of lat cycles at the output, one cycle when lat is zero
   function automatic logic tap(input logic [PD-1:0] p, input logic now, input logic [4:0] lat);
      tap = (lat <= 5'h01) ? now : p[lat - 5'h02];
   endfunction

   logic          odt_m_q, odt_s_q;      // Termination input synchroniser
   logic          cke_m_q, cke_s_q;      // Clock enable synchroniser
   logic          cke_p_q, cke_p_d;      // Clock enable one cycle back
   logic [PD-1:0] pipe_q, pipe_d;        // History of sampled termination input
   logic [7:0]    entry_q, entry_d;      // Entry period cycles left
   logic [7:0]    exit_q, exit_d;        // Exit period cycles left
   logic [7:0]    rfc_q, rfc_d;          // Refresh cycles left
   logic [2:0]    hold_q, hold_d;        // Cycles before input may drop
   odtc_status_t  stat_q, stat_d;        // Registered status
   odtc_viol_t    viol_q, viol_d;        // Registered flags
   logic          freeze;                // DLL frozen in power-down
   logic          cke_fall, cke_rise;    // Registered clock enable edges
   logic          odt_rise, odt_fall;    // Sampled termination edges
   logic          async_c;               // Respond asynchronously this cycle
   logic [4:0]    lat;                   // Synchronous on and off latency

   // Pin synchronisers, two flops before any logic
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         odt_m_q <= 1'b0;
         odt_s_q <= 1'b0;
         cke_m_q <= 1'b0;
         cke_s_q <= 1'b0;
      end else begin
         odt_m_q <= odt_pin_i;
         odt_s_q <= odt_m_q;
         cke_m_q <= cke_pin_i;
         cke_s_q <= cke_m_q;
      end
   end

   // Next state of mode tracking, termination and checks
   always_comb begin
      freeze   = ~dll_freeze_select_i;
      cke_p_d  = cke_s_q;
      cke_fall = cke_p_q & ~cke_s_q;
      cke_rise = ~cke_p_q & cke_s_q;
      odt_rise = odt_s_q & ~pipe_q[0];
      odt_fall = ~odt_s_q & pipe_q[0];
      lat      = (write_latency_i > 5'h02) ? write_latency_i - 5'h02 : 5'h00;
      // Refresh timer runs while a refresh is in progress
      rfc_d    = cmd_i.refresh ? RFC_CYC - 8'h01 : dec8(rfc_q);
      // Entry period ends at the later of command delay and refresh end
      if (cke_fall && freeze) begin
         entry_d = max8(CPDED_CYC, rfc_q);
      end else begin
         entry_d = dec8(entry_q);
      end
      // Exit period runs for the exit delay after clock enable high
      if (cke_rise && freeze) begin
         exit_d = XPDLL_CYC;
      end else begin
         exit_d = dec8(exit_q);
      end
      // Pending line entries before entry resolve early, which the lead allows
      async_c  = freeze & (~cke_s_q | (entry_q != 8'h00) | (exit_q != 8'h00));
      // While asynchronous the whole line tracks the input, so that the return
      // to synchronous timing cannot replay a stale level and glitch termination
      if (async_c) begin
         pipe_d = {PD{odt_s_q}};
      end else begin
         pipe_d = {pipe_q[PD-2:0], odt_s_q};
      end
      // Asynchronous path uses the sampled input directly, no additive delay
      if (async_c) begin
         stat_d.rtt_on = odt_s_q;
      end else begin
         stat_d.rtt_on = tap(pipe_q, odt_s_q, lat);
      end
      stat_d.async_mode = freeze & ~cke_s_q;
      stat_d.transition = freeze & ((entry_d != 8'h00) | (exit_d != 8'h00));
      stat_d.in_pd      = ~cke_s_q;
      // Minimum high time; a BL8 write restarts the count, a BC4 write only raises it to the BC4 count
      if (odt_rise) begin
         hold_d = (cmd_i.write && cmd_i.bc4) ? H4 : (cmd_i.write ? H8 : H4);
      end else if (cmd_i.write && odt_s_q) begin
         hold_d = cmd_i.bc4 ? ((hold_q > H4) ? hold_q - 3'h1 : H4) : H8;
      end else begin
         hold_d = (hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0;
      end
      // Flags are sticky and a new event wins over a clear
      viol_d.cmd_in_pd  = (viol_q.cmd_in_pd & ~viol_clr_i) |
                          (~cke_s_q & (cmd_i.read | cmd_i.write));
      viol_d.short_high = (viol_q.short_high & ~viol_clr_i) |
                          (odt_fall & (hold_q != 3'h0));
   end

   // State registers
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cke_p_q <= 1'b0;
         pipe_q  <= '0;
         entry_q <= 8'h00;
         exit_q  <= 8'h00;
         rfc_q   <= 8'h00;
         hold_q  <= 3'h0;
         stat_q  <= '0;
         viol_q  <= '0;
      end else begin
         cke_p_q <= cke_p_d;
         pipe_q  <= pipe_d;
         entry_q <= entry_d;
         exit_q  <= exit_d;
         rfc_q   <= rfc_d;
         hold_q  <= hold_d;
         stat_q  <= stat_d;
         viol_q  <= viol_d;
      end
   end

   assign status_o = stat_q;
   assign viol_o   = viol_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   // Asynchronous response never while the DLL stays on
   async_sel_a: assert property (stat_q.async_mode |-> $past(!dll_freeze_select_i))
      else $error("asynchronous mode with DLL kept on");
   // Asynchronous change follows the sample, not the latency line
   async_noal_a: assert property (async_c && (odt_s_q != tap(pipe_q, odt_s_q, lat))
      |=> stat_q.rtt_on == $past(odt_s_q))
      else $error("asynchronous path delayed by latency");
   async_on_a: assert property (async_c && odt_rise |-> ##[ON_MIN:ON_MAX] stat_q.rtt_on)
      else $error("asynchronous turn-on out of window");
   async_off_a: assert property (async_c && odt_fall |-> ##[OFF_MIN:OFF_MAX] !stat_q.rtt_on)
      else $error("asynchronous turn-off out of window");
   cmd_pd_a: assert property (!cke_s_q && cmd_i.read |=> viol_q.cmd_in_pd)
      else $error("read in power-down not flagged");
   entry_len_a: assert property (cke_fall && freeze && rfc_q == 8'h00
      |=> entry_q == CPDED_CYC && stat_q.transition)
      else $error("entry period length wrong");
   entry_rfc_a: assert property (cke_fall && freeze |=> entry_q >= $past(rfc_q))
      else $error("refresh did not extend entry period");
   trans_on_a: assert property (async_c && entry_q != 8'h00 && odt_rise
      |=> stat_q.rtt_on)
      else $error("turn-on in transition too late");
   trans_off_a: assert property (async_c && exit_q != 8'h00 && odt_fall
      |=> !stat_q.rtt_on)
      else $error("turn-off in transition too late");
   exit_len_a: assert property (cke_rise && freeze |=> exit_q == XPDLL_CYC ##1 async_c)
      else $error("exit period length wrong");
   overlap_a: assert property (freeze && entry_q != 8'h00 && exit_q != 8'h00
      |=> stat_q.rtt_on == $past(odt_s_q))
      else $error("overlap lost asynchronous response");

   async_on_c: cover property (async_c && odt_rise ##1 stat_q.rtt_on);
   overlap_c: cover property (entry_q != 8'h00 && exit_q != 8'h00);
   short_c: cover property (odt_fall && hold_q != 3'h0);
   rfc_c: cover property (cke_fall && freeze && rfc_q > CPDED_CYC);

endmodule // odtc_top

/* tb/odtc_ctrl_model.sv */
// Controller model: drives termination, clock enable and decoded commands
`timescale 1ns/10ps
module odtc_ctrl_model
   import odtc_pkg::*;
(
   input  wire logic clk_i,      // Memory clock
   output logic      odt_pin_o,  // Termination input
   output logic      cke_pin_o,  // Clock enable
   output odtc_cmd_t cmd_o       // One-cycle command pulses
);
   // Idle levels from time zero, clock enabled
   initial begin
      odt_pin_o = 1'b0;
      cke_pin_o = 1'b1;
      cmd_o = '0;
   end
   // Let n edges pass, then step just past the last one
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Level changes, always made just after an edge
   task automatic set_pins(input logic termination_input, input logic cke);
      odt_pin_o = termination_input;
      cke_pin_o = cke;
   endtask
   // One-cycle command, dropped after its sampling edge
   task automatic issue(input odtc_cmd_t c);
      cmd_o = c;
      tick(1);
      cmd_o = '0;
   endtask
   // Termination high n cycles, three at least; write lands with the synchronised rise
   task automatic odt_burst(input int n, input logic wr, input logic bc4);
      odt_pin_o = 1'b1;
      tick(2);
      issue(odtc_cmd_t'{wr, bc4, 1'b0, 1'b0});
      if (n > 3) begin
         tick(n - 3);
      end
      odt_pin_o = 1'b0;
   endtask
endmodule // odtc_ctrl_model

/* tb/odtc_top_bench.sv */
// Self-checking bench for the termination control block
`timescale 1ns/10ps
module odtc_top_bench;
   import odtc_pkg::*;
   localparam logic [7:0] CPDED = 8'h01;  // Command delay, same as the default
   localparam logic [7:0] XPDLL = 8'h04;  // Shortened exit delay
   localparam logic [7:0] RFC   = 8'h08;  // Shortened refresh time
   logic         clk_i = 1'b0;     // 25 MHz clock
   logic         nrst_i = 1'b0;    // Reset, held at start
   logic         freeze = 1'b1;    // Frozen DLL select
   logic         viol_clr = 1'b0;  // Flag clear pulse
   logic [4:0]   wl = 5'h08;       // Write latency
   logic         termination_input, cke;         // Pins from the model
   odtc_cmd_t    cmd;              // Commands from the model
   odtc_status_t st;               // Termination state
   odtc_viol_t   vl;               // Misuse flags
   int           miscompares = 0;  // Failed comparisons
   int           n_tests = 0;      // All comparisons
   // Clock, 40 ns period
   always #20 clk_i = ~clk_i;
   odtc_ctrl_model ctl (.clk_i(clk_i), .odt_pin_o(termination_input), .cke_pin_o(cke), .cmd_o(cmd));
   odtc_top #(.CPDED_CYC(CPDED), .XPDLL_CYC(XPDLL), .RFC_CYC(RFC)) dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .odt_pin_i(termination_input), .cke_pin_i(cke),
      .dll_freeze_select_i(freeze), .write_latency_i(wl), .cmd_i(cmd),
      .viol_clr_i(viol_clr), .status_o(st), .viol_o(vl));
   // Report, verdict and end of run
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Single-bit compare
   task automatic chk(input logic act, input logic exp, input string msg);
      n_tests++;
      if (act !== exp) begin
         miscompares++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask
   // Step until a status bit takes a value, bounded; n returns cycles taken
   task automatic wait_st(input int idx, input logic v, input int lim, output int n);
      n = 0;
      while (st[idx] !== v) begin
         if (n == lim) begin
            miscompares++;
            $display("MISMATCH %0t status wait expired", $time);
            finish_test();
         end
         ctl.tick(1);
         n++;
      end
   endtask
   // Synchronous mode: response waits for the latency line, run per latency
   task automatic t_sync(input logic [4:0] lat_cyc);
      int n;
      wl = lat_cyc;
      ctl.set_pins(1'b1, 1'b1);
      ctl.tick(3);
      chk(st.rtt_on, 1'b0, "sync too early");
      wait_st(3, 1'b1, 16, n);
      chk(n == wl - 3, 1'b1, "sync turn-on latency");
      chk(st.async_mode, 1'b0, "async while select is one");
      ctl.set_pins(1'b0, 1'b1);
      wait_st(3, 1'b0, 16, n);
      chk(n == wl, 1'b1, "sync turn-off latency");
   endtask
   // Hold-time table: lengths, write kinds and expected flag
   task automatic t_hold();
      int len [4] = '{3, 5, 6, 4};
      logic [3:0] wr = 4'he, bc = 4'h8, bad = 4'h3;
      for (int i = 0; i < 4; i++) begin
         viol_clr = 1'b1;
         ctl.tick(1);
         viol_clr = 1'b0;
         ctl.odt_burst(len[i], wr[i], bc[i]);
         ctl.tick(4);
         chk(vl.short_high, bad[i], "hold flag");
      end
   endtask
   // Entry, asynchronous response in power-down, command misuse
   task automatic t_entry();
      int n;
      ctl.set_pins(1'b0, 1'b0);
      ctl.tick(3);
      chk(st.in_pd & st.async_mode & st.transition, 1'b1, "entry");
      wait_st(1, 1'b0, 80, n);
      chk(n == CPDED, 1'b1, "entry length");
      for (int v = 1; v >= 0; v--) begin
         ctl.set_pins(v[0], 1'b0);
         ctl.tick(2);
         chk(st.rtt_on, ~v[0], "async too early");
         ctl.tick(1);
         chk(st.rtt_on, v[0], "async late");
      end
      ctl.issue(odtc_cmd_t'{1'b0, 1'b0, 1'b1, 1'b0});
      ctl.tick(1);
      chk(vl.cmd_in_pd, 1'b1, "read in power-down");
      viol_clr = 1'b1;
      ctl.tick(1);
      viol_clr = 1'b0;
      ctl.tick(1);
      chk(vl.cmd_in_pd, 1'b0, "flag clear");
   endtask
   // Exit, then termination raised inside the exit period
   task automatic t_exit();
      int n;
      ctl.set_pins(1'b0, 1'b1);
      ctl.tick(3);
      chk(st.transition & ~st.in_pd & ~st.async_mode, 1'b1, "exit");
      ctl.set_pins(1'b1, 1'b1);
      ctl.tick(3);
      chk(st.transition & st.rtt_on, 1'b1, "turn-on in exit");
      wait_st(1, 1'b0, 80, n);
      chk(n + 3 == XPDLL, 1'b1, "exit length");
      ctl.set_pins(1'b0, 1'b1);
      ctl.tick(3);
      chk(st.rtt_on, 1'b1, "sync after exit");
      wait_st(3, 1'b0, 16, n);
      chk(n == wl - 3, 1'b1, "sync turn-off after exit");
   endtask
   // Refresh running at entry stretches the entry period
   task automatic t_refresh();
      int n;
      ctl.issue(odtc_cmd_t'{1'b0, 1'b0, 1'b0, 1'b1});
      ctl.set_pins(1'b0, 1'b0);
      ctl.tick(3);
      wait_st(1, 1'b0, 80, n);
      chk(n == RFC - 3, 1'b1, "refresh entry length");
      ctl.set_pins(1'b0, 1'b1);
      ctl.tick(3);
      wait_st(1, 1'b0, 80, n);
      chk(n == XPDLL, 1'b1, "exit after refresh entry");
   endtask
   // Short power-down: refresh-stretched entry overlaps the exit period
   task automatic t_overlap();
      int n;
      ctl.issue(odtc_cmd_t'{1'b0, 1'b0, 1'b0, 1'b1});
      ctl.set_pins(1'b0, 1'b0);
      ctl.tick(3);
      ctl.set_pins(1'b1, 1'b1);
      ctl.tick(3);
      chk(st.rtt_on & st.transition, 1'b1, "overlap response");
      wait_st(1, 1'b0, 80, n);
      chk(n == XPDLL, 1'b1, "overlap ends with exit");
      ctl.set_pins(1'b0, 1'b1);
      wait_st(3, 1'b0, 16, n);
      chk(n == wl, 1'b1, "sync after overlap");
   endtask
   // Main sequence
   initial begin
      ctl.tick(2);
      chk(|{st, vl}, 1'b0, "outputs in reset");
      ctl.tick(1);
      nrst_i = 1'b1;
      ctl.tick(4);
      t_sync(5'h08);
      t_sync(5'h05);
      t_hold();
      freeze = 1'b0;
      ctl.tick(1);
      t_entry();
      t_exit();
      t_refresh();
      t_overlap();
      finish_test();
   end
endmodule // odtc_top_bench
